// ==== design/ocrs_card_regs.sv ====
// Card register set: operating conditions and word reads of all registers except the driver stage register.
`timescale 1ns/1ps

module ocrs_card_regs (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Power-up events from the controller
  input wire logic i_init_done,
  input wire logic i_go_idle,
  // Register contents held by the controller
  input wire logic [127:0] i_card_identity_block,
  input wire logic [127:0] i_card_specific_data,
  input wire logic [63:0] i_special_features_config,
  input wire logic [511:0] i_status_block,
  // Relative address write
  input wire logic i_rca_wr,
  input wire logic [15:0] i_rca_data,
  // Read request
  input wire logic i_rd_req,
  input wire logic [2:0] i_rd_sel,
  input wire logic [3:0] i_rd_word,
  // Read answer
  output logic o_rd_valid,
  output logic o_rd_err,
  output logic o_rd_card_specific,
  output logic [31:0] o_rd_data,
  // Direct views
  output logic [31:0] o_operating_conditions,
  output logic [15:0] o_relative_card_addr
);
  typedef struct packed {
    logic [15:0] relative_card_addr;
    logic rd_valid;
    logic rd_err;
    logic rd_spec;
    logic [31:0] rd_data;
  } ocrs_state_t;

  ocrs_state_t st_r;
  ocrs_state_t st_nxt;
  logic ready;
  logic [31:0] operating_conditions;
  logic [511:0] src;
  logic [3:0] last_word;
  logic known;

  ocrs_pwrup_flag u_pwrup (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_init_done(i_init_done),
    .i_go_idle(i_go_idle),
    .o_ready(ready)
  );

  // --------------------------------------------------------------------------
  // Operating conditions
  // --------------------------------------------------------------------------
  // Capacity, switch and reserved bits are constant zeros in the base value.
  always_comb begin
    operating_conditions = ocrs_pkg::OCRS_OCR_BASE;
    operating_conditions[ocrs_pkg::OCRS_BIT_READY] = ready;
  end

  // --------------------------------------------------------------------------
  // Read source selection
  // --------------------------------------------------------------------------
  always_comb begin
    src = '0;
    last_word = 4'h0;
    known = 1'b1;
    unique case (ocrs_pkg::ocrs_sel_t'(i_rd_sel))
      ocrs_pkg::OCRS_SEL_OCR: begin
        src[31:0] = operating_conditions;
        last_word = ocrs_pkg::OCRS_WORDS_OCR;
      end
      ocrs_pkg::OCRS_SEL_CID: begin
        src[127:0] = i_card_identity_block;
        last_word = ocrs_pkg::OCRS_WORDS_CID;
      end
      ocrs_pkg::OCRS_SEL_CSD: begin
        src[127:0] = i_card_specific_data;
        last_word = ocrs_pkg::OCRS_WORDS_CSD;
      end
      ocrs_pkg::OCRS_SEL_RCA: begin
        src[15:0] = st_r.relative_card_addr;
        last_word = ocrs_pkg::OCRS_WORDS_RCA;
      end
      ocrs_pkg::OCRS_SEL_SCR: begin
        src[63:0] = i_special_features_config;
        last_word = ocrs_pkg::OCRS_WORDS_SCR;
      end
      ocrs_pkg::OCRS_SEL_STAT: begin
        src = i_status_block;
        last_word = ocrs_pkg::OCRS_WORDS_STAT;
      end
      // The driver stage register has no storage; reads are refused.
      ocrs_pkg::OCRS_SEL_DSR: known = 1'b0;
      ocrs_pkg::OCRS_SEL_NONE: known = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // State update
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = i_rd_req;
    if (i_rca_wr) begin
      st_nxt.relative_card_addr = i_rca_data;
    end
    if (i_rd_req) begin
      st_nxt.rd_err = !known || (i_rd_word > last_word);
      st_nxt.rd_spec = (i_rd_sel == ocrs_pkg::OCRS_SEL_STAT);
      if (known && (i_rd_word <= last_word)) begin
        st_nxt.rd_data = src[32 * i_rd_word +: 32];
      end else begin
        st_nxt.rd_data = ocrs_pkg::OCRS_DATA_RST;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r.relative_card_addr <= ocrs_pkg::OCRS_RCA_RST;
      st_r.rd_valid <= 1'b0;
      st_r.rd_err <= 1'b0;
      st_r.rd_spec <= 1'b0;
      st_r.rd_data <= ocrs_pkg::OCRS_DATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rd_valid = st_r.rd_valid;
  assign o_rd_err = st_r.rd_err;
  assign o_rd_card_specific = st_r.rd_spec;
  assign o_rd_data = st_r.rd_data;
  assign o_operating_conditions = operating_conditions;
  assign o_relative_card_addr = st_r.relative_card_addr;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_ocr_read;
    i_rd_req && i_rd_sel == ocrs_pkg::OCRS_SEL_OCR && i_rd_word == 4'h0;
  endsequence

  sequence s_answer_ok;
    o_rd_valid && !o_rd_err;
  endsequence

  // All checks are off during reset, when outputs sit at their idle values.
  a_window_ones: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    o_operating_conditions[ocrs_pkg::OCRS_WIN_HI:ocrs_pkg::OCRS_WIN_LO]
    == ocrs_pkg::OCRS_WIN_MASK)
    else $error("voltage window bits not all one");

  a_reserved_zero: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    (o_operating_conditions & ocrs_pkg::OCRS_OCR_RSVD) == 32'h0000_0000)
    else $error("reserved bit set");

  a_fixed_flags: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    !o_operating_conditions[ocrs_pkg::OCRS_BIT_CAP]
    && !o_operating_conditions[ocrs_pkg::OCRS_BIT_LVSW])
    else $error("capacity or switch flag set");

  a_busy_idle: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    i_go_idle && !i_init_done |=> !o_operating_conditions[31])
    else $error("ready after return to idle");

  a_busy_keep: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    !o_operating_conditions[31] && !i_init_done
    |=> !o_operating_conditions[31])
    else $error("busy flag left without init done");

  a_ready_hold: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    i_init_done |=> o_operating_conditions[31] [*1] ##1 1'b1)
    else $error("ready not set after init done");

  a_ready_keep: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    o_operating_conditions[31] && !i_go_idle
    |=> o_operating_conditions[31])
    else $error("ready dropped without return to idle");

  a_ocr_read: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    s_ocr_read |=> s_answer_ok and o_rd_data == $past(operating_conditions))
    else $error("operating conditions read wrong");

  a_ocr_width: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    i_rd_req && i_rd_sel == ocrs_pkg::OCRS_SEL_OCR && i_rd_word != 4'h0
    |=> o_rd_err)
    else $error("word beyond operating conditions accepted");

  a_dsr_refused: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    i_rd_req && i_rd_sel == ocrs_pkg::OCRS_SEL_DSR
    |=> o_rd_valid && o_rd_err && o_rd_data == 32'h0000_0000)
    else $error("driver stage read not refused");

  a_error_zero: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    o_rd_err |-> o_rd_data == 32'h0000_0000)
    else $error("refused read returned data");

  a_rca_store: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    i_rca_wr ##1 (i_rd_req && i_rd_sel == ocrs_pkg::OCRS_SEL_RCA
    && i_rd_word == 4'h0) |=> o_rd_data[15:0] == $past(i_rca_data, 2))
    else $error("address register readback wrong");

  a_rca_direct: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    i_rca_wr |=> o_relative_card_addr == $past(i_rca_data))
    else $error("address register not updated");

  a_valid_pulse: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    o_rd_valid == $past(i_rd_req))
    else $error("read answer not one cycle after request");

  a_stat_group: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    i_rd_req |=> o_rd_card_specific == ($past(i_rd_sel) ==
    ocrs_pkg::OCRS_SEL_STAT))
    else $error("register group flag wrong");

  a_stat_words: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    i_rd_req && i_rd_sel == ocrs_pkg::OCRS_SEL_STAT |=> !o_rd_err)
    else $error("status block word refused");

  a_word_range: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    i_rd_req && i_rd_sel == ocrs_pkg::OCRS_SEL_SCR && i_rd_word > 4'h1
    |=> o_rd_err)
    else $error("out of range word accepted");
endmodule : ocrs_card_regs

// ==== design/ocrs_defs.sv ====
// Constants of the card register set and its power-up status tracker.

`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package ocrs_pkg;
  localparam int OCRS_OCR_W = 32;
  localparam int OCRS_CID_W = 128;
  localparam int OCRS_CSD_W = 128;
  localparam int OCRS_RCA_W = 16;
  localparam int OCRS_DSR_W = 16;
  localparam int OCRS_SCR_W = 64;
  localparam int OCRS_STAT_W = 512;
  localparam int OCRS_WORD_W = 32;

  localparam int OCRS_BIT_READY = 31;
  localparam int OCRS_BIT_CAP = 30;
  localparam int OCRS_BIT_LVSW = 24;
  localparam int OCRS_WIN_HI = 23;
  localparam int OCRS_WIN_LO = 15;
  localparam logic [8:0] OCRS_WIN_MASK = 9'h1FF;
  localparam logic [31:0] OCRS_OCR_BASE = 32'h00FF_8000;
  localparam logic [31:0] OCRS_OCR_RSVD = 32'h3E00_7FFF;

  localparam logic [15:0] OCRS_RCA_RST = 16'h0000;
  localparam logic [31:0] OCRS_DATA_RST = 32'h0000_0000;

  localparam logic [3:0] OCRS_WORDS_OCR = 4'h0;
  localparam logic [3:0] OCRS_WORDS_CID = 4'h3;
  localparam logic [3:0] OCRS_WORDS_CSD = 4'h3;
  localparam logic [3:0] OCRS_WORDS_RCA = 4'h0;
  localparam logic [3:0] OCRS_WORDS_SCR = 4'h1;
  localparam logic [3:0] OCRS_WORDS_STAT = 4'hF;

  typedef enum logic [2:0] {
    OCRS_SEL_OCR = 3'b000,
    OCRS_SEL_CID = 3'b001,
    OCRS_SEL_CSD = 3'b010,
    OCRS_SEL_RCA = 3'b011,
    OCRS_SEL_DSR = 3'b100,
    OCRS_SEL_SCR = 3'b101,
    OCRS_SEL_STAT = 3'b110,
    OCRS_SEL_NONE = 3'b111
  } ocrs_sel_t;
endpackage : ocrs_pkg

// ----------------------------------------------------------------------------
// Power-up status flag
// ----------------------------------------------------------------------------
module ocrs_pwrup_flag (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Events from the controller
  input wire logic i_init_done,
  input wire logic i_go_idle,
  // Flag
  output logic o_ready
);
  typedef struct packed {
    logic ready;
  } ocrs_flag_t;

  ocrs_flag_t st_r;
  ocrs_flag_t st_nxt;

  // Completion wins over a return to idle in the same cycle, so a finished
  // initialisation is never lost.
  always_comb begin
    st_nxt = st_r;
    if (i_go_idle) begin
      st_nxt.ready = 1'b0;
    end
    if (i_init_done) begin
      st_nxt.ready = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ready = st_r.ready;

  a_ready_cause: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    $rose(o_ready) |-> $past(i_init_done))
    else $error("ready rose without init done");
endmodule : ocrs_pwrup_flag

// ==== tb/ocrs_host_model.sv ====
// Host model that issues register reads and polls the power-up flag.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Host side of the command line
// ----------------------------------------------------------------------
module ocrs_host_model (
  // Clock and answer
  input wire logic i_mclk,
  input wire logic i_rd_valid,
  input wire logic [31:0] i_rd_data,
  // Requests
  output logic o_rd_req = 1'b0,
  output logic [2:0] o_rd_sel = 3'h0,
  output logic [3:0] o_rd_word = 4'h0,
  output logic o_polling = 1'b0
);
  task automatic rd(input logic [2:0] s, input logic [3:0] w);
    @(posedge i_mclk);
    o_rd_req <= 1'b1;
    o_rd_sel <= s;
    o_rd_word <= w;
    @(posedge i_mclk);
    o_rd_req <= 1'b0;
    o_rd_sel <= ~s;
    o_rd_word <= ~w;
  endtask : rd

  // A host gives up after lim tries and treats the part as absent.
  task automatic poll(input int lim, output logic ok);
    int n;
    ok = 1'b0;
    o_polling <= 1'b1;
    for (n = 0; n < lim && !ok; n++) begin
      rd(3'h0, 4'h0);
      @(posedge i_mclk);
      ok = i_rd_valid & i_rd_data[31];
    end
    o_polling <= 1'b0;
  endtask : poll
endmodule : ocrs_host_model

// ==== tb/ocrs_card_regs_tb.sv ====
// Self-checking bench for the card register set.
`timescale 1ns/1ps

module ocrs_card_regs_tb;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic init_done = 1'b0, go_idle = 1'b0, rca_wr = 1'b0, rdy = 1'b0;
  logic [15:0] rca_data = 16'h0000, rca_exp = 16'h0000, relative_card_addr;
  logic [127:0] card_identity_block, card_specific_data;
  logic [63:0] special_features_config;
  logic [511:0] stat;
  logic rd_req, rd_valid, rd_err, rd_cs, polling, ok;
  logic [2:0] rd_sel;
  logic [3:0] rd_word;
  logic [31:0] rd_data, operating_conditions;
  logic [33:0] q[$];
  logic [33:0] e;
  int num_errors = 0, checks = 0, seed = 18080, i, j;

  initial begin
    forever #50 i_mclk = ~i_mclk;
  end

  ocrs_card_regs u_ocrs_card_regs (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_init_done(init_done), .i_go_idle(go_idle),
    .i_card_identity_block(card_identity_block), .i_card_specific_data(card_specific_data),
    .i_special_features_config(special_features_config), .i_status_block(stat),
    .i_rca_wr(rca_wr), .i_rca_data(rca_data), .i_rd_req(rd_req),
    .i_rd_sel(rd_sel), .i_rd_word(rd_word), .o_rd_valid(rd_valid),
    .o_rd_err(rd_err), .o_rd_card_specific(rd_cs), .o_rd_data(rd_data),
    .o_operating_conditions(operating_conditions), .o_relative_card_addr(relative_card_addr));

  ocrs_host_model u_host (.i_mclk(i_mclk), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .o_rd_req(rd_req), .o_rd_sel(rd_sel),
    .o_rd_word(rd_word), .o_polling(polling));

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [33:0] expv(input logic [2:0] s,
                                       input logic [3:0] w);
    logic [511:0] v;
    logic [3:0] lw;
    v = '0;
    lw = 4'h0;
    case (s)
      3'h0: v[31:0] = {rdy, 31'h00FF_8000};
      3'h1: begin v[127:0] = card_identity_block; lw = 4'h3; end
      3'h2: begin v[127:0] = card_specific_data; lw = 4'h3; end
      3'h3: v[15:0] = rca_exp;
      3'h5: begin v[63:0] = special_features_config; lw = 4'h1; end
      3'h6: begin v = stat; lw = 4'hF; end
      default: lw = 4'h0;
    endcase
    if (s == 3'h4 || s == 3'h7 || w > lw) return {2'b10, 32'h0000_0000};
    return {1'b0, s == 3'h6, v[32*w+:32]};
  endfunction : expv

  task automatic rd(input logic [2:0] s, input logic [3:0] w);
    q.push_back(expv(s, w));
    u_host.rd(s, w);
    @(posedge i_mclk);
  endtask : rd

  always @(posedge i_mclk) begin
    if (rd_valid === 1'b1 && polling !== 1'b1) begin
      e = q.size() ? q.pop_front() : 'x;
      chk({rd_err, rd_cs, rd_data}, e);
    end
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    #500000;
    num_errors++;
    give_verdict;
  end

  initial begin
    for (i = 0; i < 16; i++) stat[32*i+:32] = $random(seed);
    card_identity_block = {$random(seed), $random(seed), $random(seed), $random(seed)};
    card_specific_data = {$random(seed), $random(seed), $random(seed), $random(seed)};
    special_features_config = {$random(seed), $random(seed)};
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    chk(operating_conditions, 32'h00FF_8000);
    chk(relative_card_addr, 16'h0000);
    $display("reset test done");
    u_host.poll(3, ok);
    chk(ok, 1'b0);
    init_done <= 1'b1;
    @(posedge i_mclk);
    init_done <= 1'b0;
    rdy = 1'b1;
    @(posedge i_mclk);
    chk(operating_conditions, 32'h80FF_8000);
    u_host.poll(3, ok);
    chk(ok, 1'b1);
    $display("power-up test done");
    for (i = 0; i < 8; i++)
      for (j = 0; j < 16; j++) rd(i[2:0], j[3:0]);
    $display("read map test done");
    rca_exp = 16'($random(seed));
    rca_data <= rca_exp;
    rca_wr <= 1'b1;
    // The read follows the write strobe directly, as a host may do.
    fork
      rd(3'h3, 4'h0);
      begin
        @(posedge i_mclk);
        rca_wr <= 1'b0;
      end
    join
    chk(relative_card_addr, rca_exp);
    rd(3'h3, 4'h1);
    $display("address test done");
    go_idle <= 1'b1;
    @(posedge i_mclk);
    go_idle <= 1'b0;
    rdy = 1'b0;
    @(posedge i_mclk);
    chk(operating_conditions, 32'h00FF_8000);
    init_done <= 1'b1;
    go_idle <= 1'b1;
    @(posedge i_mclk);
    init_done <= 1'b0;
    go_idle <= 1'b0;
    rdy = 1'b1;
    rd(3'h0, 4'h0);
    chk(operating_conditions, 32'h80FF_8000);
    repeat (3) @(posedge i_mclk);
    chk(q.size(), 0);
    $display("idle test done");
    i_rst <= 1'b1;
    @(posedge i_mclk);
    chk(operating_conditions, 32'h00FF_8000);
    chk(relative_card_addr, 16'h0000);
    i_rst <= 1'b0;
    rdy = 1'b0;
    rca_exp = 16'h0000;
    rd(3'h0, 4'h0);
    rd(3'h3, 4'h0);
    repeat (3) @(posedge i_mclk);
    chk(q.size(), 0);
    $display("second reset test done");
    give_verdict;
  end
endmodule : ocrs_card_regs_tb
